// File: rtl/crtcfb_pkg.sv
/*
 Package for the frame buffer address mapper: register indices, field
 positions, reset values and mode enumerations.
 Assumes a single mclk domain and an indexed index/data port pair.
*/
// How it works
// (RULE1) Byte mode passes counter bits straight through
// (RULE2) Word no-wrap: bit0 from bit15, rest shifted
// (RULE3) Word wrap: bit0 from bit13, rest shifted
// (RULE4) Doubleword: bits0,1 from 12,13, shift two
// (RULE5) Row scan bits replace address bits 13/14
// (RULE6) Line compare is ten bits from three registers
// (RULE7) Address counter restarts at zero at compare line
// (RULE8) Lines above compare start at start address
// (RULE9) Latch data reads latch picked by map select
// (RULE10) Standard mode: ten bit vertical total
// (RULE11) Extended mode: twelve bit vertical total
// (RULE12) Extension bits ignored in standard mode
// (RULE13) Software programs total lines minus two
// (RULE14) Software writes zero to reserved bits
// (RULE15) Registers reached through index then data port
// (RULE16) Word mode wrap bit 0 wraps at 16KB
// (RULE17) Mapping is combinational from current counters
package crtcfb_pkg;
   localparam logic [7:0] IDX_START_HIGH   = 8'h0C;
   localparam logic [7:0] IDX_START_LOW    = 8'h0D;
   localparam logic [7:0] IDX_VTOTAL_LOW   = 8'h06;
   localparam logic [7:0] IDX_OVERFLOW     = 8'h07;
   localparam logic [7:0] IDX_MAX_SCAN     = 8'h09;
   localparam logic [7:0] IDX_UNDERLINE    = 8'h14;
   localparam logic [7:0] IDX_MODE_CTRL    = 8'h17;
   localparam logic [7:0] IDX_LINE_CMP     = 8'h18;
   localparam logic [7:0] IDX_LATCH_DATA   = 8'h22;
   localparam logic [7:0] IDX_VTOTAL_HIGH  = 8'h30;
   // Mode control and underline fields
   localparam int MC_WORD_BYTE  = 6;
   localparam int MC_WRAP       = 5;
   localparam int MC_ROW_SEL    = 1;
   localparam int MC_COMPAT     = 0;
   localparam int UL_DWORD      = 6;
   // Overflow and max scan fields
   localparam int OV_LCMP_B8    = 4;
   localparam int OV_VT_B9      = 5;
   localparam int OV_VT_B8      = 0;
   localparam int MS_LCMP_B9    = 6;
   // Reset values
   localparam logic [7:0] RST_MODE_CTRL = 8'hE3;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_LINE_CMP  = 8'hFF;
   localparam logic [7:0] RST_OVERFLOW  = 8'h10;
   localparam logic [7:0] RST_MAX_SCAN  = 8'h40;
   typedef enum logic [1:0] {
      CRTCFB_BYTE  = 2'b00,
      CRTCFB_WORDN = 2'b01,
      CRTCFB_WORDW = 2'b10,
      CRTCFB_DWORD = 2'b11
   } crtcfb_mode_t;
endpackage

// File: rtl/crtcfb_remap.sv
/*
 Combinational address reorganizer and row scan substitution.
 Assumes mode bits come from registers in the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module crtcfb_remap
(
   input  wire logic                    mode_byte_n,
   input  wire logic                    dword_sel,
   input  wire logic                    no_wrap,
   input  wire logic                    compat_n,
   input  wire logic                    row_sel_n,
   input  wire logic [15:0]             count_addr,
   input  wire logic [1:0]              row_scan,
   output var crtcfb_pkg::crtcfb_mode_t mode,
   output logic [15:0]                  reorganized_address_out,
   output logic [15:0]                  decoder_address_in
);
   import crtcfb_pkg::*;

   // Mode decode: doubleword overrides the other bits
   always_comb
   begin
      if (dword_sel)
         mode = CRTCFB_DWORD;
      else if (mode_byte_n)
         mode = CRTCFB_BYTE;
      else if (no_wrap)
         mode = CRTCFB_WORDN;
      else
         mode = CRTCFB_WORDW;
   end

   // Reorganize; no register so fetch follows mode bits at once
   always_comb
   begin
      case (mode) // RULE17
         CRTCFB_BYTE:  reorganized_address_out = count_addr; // RULE1
         CRTCFB_WORDN: reorganized_address_out =
                          {count_addr[14:0], count_addr[15]}; // RULE2
         CRTCFB_WORDW: reorganized_address_out =
                          {count_addr[14:0], count_addr[13]}; // RULE3 RULE16
         default:      reorganized_address_out =
                          {count_addr[13:0], count_addr[13:12]}; // RULE4
      endcase
   end

   // Row scan substitution after the shift stage
   always_comb
   begin
      decoder_address_in = reorganized_address_out;
      if (!compat_n)
         decoder_address_in[13] = row_scan[0]; // RULE5
      if (!row_sel_n)
         decoder_address_in[14] = row_scan[1]; // RULE5
   end
endmodule // crtcfb_remap
`default_nettype wire

// File: rtl/crtcfb_top.sv
/*
 Frame buffer address mapper top: indexed register port, line compare
 restart of the address counter, read latch data port and vertical total.
 Assumes index/data strobes are single-cycle pulses on mclk, produced by
 same-domain host decode logic; char/line strobes come from CRT timing.
*/
`timescale 1ns/10ps
`default_nettype none
module crtcfb_top
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        index_wr,
   input  wire logic        data_wr,
   input  wire logic        data_rd,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata,
   output logic      [7:0]  index_value,
   input  wire logic        ext_mode,
   input  wire logic [1:0]  read_map_select,
   input  wire logic [31:0] read_latches,
   input  wire logic        frame_start,
   input  wire logic        line_start,
   input  wire logic        char_advance,
   input  wire logic        active_line,
   input  wire logic [9:0]  scan_line,
   input  wire logic [1:0]  row_scan_counter_out,
   input  wire logic        row_last,
   output logic      [15:0] count_addr,
   output logic      [15:0] reorganized_address_out,
   output logic      [15:0] decoder_address_in,
   output logic      [9:0]  line_compare,
   output logic      [11:0] vertical_total,
   output logic             split_active
);
   import crtcfb_pkg::*;

   logic [7:0]   start_address_high;
   logic [7:0]   start_address_low;
   logic [7:0]   vertical_total_low;
   logic [7:0]   overflow_reg;
   logic [7:0]   max_scan_line_reg;
   logic [7:0]   underline_location_reg;
   logic [7:0]   crt_mode_control;
   logic [7:0]   line_compare_low;
   logic [3:0]   vertical_total_high;
   logic [15:0]  line_base;
   logic [15:0]  next_count;
   logic         cmp_hit;
   logic [15:0]  start_address;
   logic [7:0]   latch_pick;
   crtcfb_mode_t mode;

   // Every check in this module runs on mclk and sleeps through reset;
   // the reset is synchronous, so nothing is checked while nrst is low
   default clocking chk_clk @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // Index port holds the register selector for data accesses
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         index_value <= RST_ZERO;
      else if (index_wr)
         index_value <= host_wdata; // RULE15
   end

   // Data port writes; read-only latch index ignores writes
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         start_address_high     <= RST_ZERO;
         start_address_low      <= RST_ZERO;
         vertical_total_low     <= RST_ZERO;
         overflow_reg           <= RST_OVERFLOW;
         max_scan_line_reg      <= RST_MAX_SCAN;
         underline_location_reg <= RST_ZERO;
         crt_mode_control       <= RST_MODE_CTRL;
         line_compare_low       <= RST_LINE_CMP;
         vertical_total_high    <= RST_ZERO[3:0];
      end
      else if (data_wr)
      begin
         if (index_value == IDX_START_HIGH)
            start_address_high <= host_wdata;
         else if (index_value == IDX_START_LOW)
            start_address_low <= host_wdata;
         else if (index_value == IDX_VTOTAL_LOW)
            vertical_total_low <= host_wdata;
         else if (index_value == IDX_OVERFLOW)
            overflow_reg <= host_wdata;
         else if (index_value == IDX_MAX_SCAN)
            max_scan_line_reg <= host_wdata;
         else if (index_value == IDX_UNDERLINE)
            underline_location_reg <= host_wdata;
         else if (index_value == IDX_MODE_CTRL)
            crt_mode_control <= host_wdata;
         else if (index_value == IDX_LINE_CMP)
            line_compare_low <= host_wdata; // RULE15
         else if (index_value == IDX_VTOTAL_HIGH)
            vertical_total_high <= host_wdata[3:0]; // Reserved bits dropped
      end
   end

   // Read mux registered; reserved high bits of the extension read zero
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         host_rdata <= RST_ZERO;
      else if (data_rd)
      begin
         if (index_value == IDX_START_HIGH)
            host_rdata <= start_address_high;
         else if (index_value == IDX_START_LOW)
            host_rdata <= start_address_low;
         else if (index_value == IDX_VTOTAL_LOW)
            host_rdata <= vertical_total_low;
         else if (index_value == IDX_OVERFLOW)
            host_rdata <= overflow_reg;
         else if (index_value == IDX_MAX_SCAN)
            host_rdata <= max_scan_line_reg;
         else if (index_value == IDX_UNDERLINE)
            host_rdata <= underline_location_reg;
         else if (index_value == IDX_MODE_CTRL)
            host_rdata <= crt_mode_control;
         else if (index_value == IDX_LINE_CMP)
            host_rdata <= line_compare_low;
         else if (index_value == IDX_LATCH_DATA)
            host_rdata <= latch_pick; // RULE9
         else if (index_value == IDX_VTOTAL_HIGH)
            host_rdata <= {4'h0, vertical_total_high};
         else
            host_rdata <= RST_ZERO;
      end
   end

   // Start address and selected latch, shared by datapath and checks
   assign start_address = {start_address_high, start_address_low};
   assign latch_pick    = read_latches[read_map_select*8 +: 8]; // RULE9

   // Ten bit compare value assembled from three registers
   assign line_compare = {max_scan_line_reg[MS_LCMP_B9],
                          overflow_reg[OV_LCMP_B8],
                          line_compare_low}; // RULE6

   // Extension nibble only counts in extended mode
   always_comb
   begin
      if (ext_mode)
         vertical_total = {vertical_total_high, vertical_total_low}; // RULE11
      else
         vertical_total = {2'b00, overflow_reg[OV_VT_B9],
                           overflow_reg[OV_VT_B8],
                           vertical_total_low}; // RULE10 RULE12
   end

   assign cmp_hit = line_start && active_line && (scan_line == line_compare);

   // Counter: zero from the compare line on, start address each frame.
   // Compare wins over frame start, so a compare value of zero still
   // splits from the first line instead of being masked by the reload.
   always_comb
   begin
      next_count = count_addr;
      if (cmp_hit)
         next_count = 16'h0000; // RULE7
      else if (frame_start)
         next_count = start_address; // RULE8
      else if (line_start)
         next_count = line_base;
      else if (char_advance)
         next_count = count_addr + 16'h0001;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         count_addr <= 16'h0000;
      else
         count_addr <= next_count;
   end

   // Line base takes the counter only at the start of the last row of a character line
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         line_base <= 16'h0000;
      else if (cmp_hit)
         line_base <= 16'h0000; // RULE7
      else if (frame_start)
         line_base <= start_address; // RULE8
      else if (line_start && row_last)
         line_base <= count_addr;
   end

   // Split flag marks lower part of display; set wins over frame clear
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         split_active <= 1'b0;
      else if (cmp_hit)
         split_active <= 1'b1; // RULE7
      else if (frame_start)
         split_active <= 1'b0;
   end

   crtcfb_remap u_remap
   (
      .mode_byte_n             (crt_mode_control[MC_WORD_BYTE]),
      .dword_sel               (underline_location_reg[UL_DWORD]),
      .no_wrap                 (crt_mode_control[MC_WRAP]),
      .compat_n                (crt_mode_control[MC_COMPAT]),
      .row_sel_n               (crt_mode_control[MC_ROW_SEL]),
      .count_addr              (count_addr),
      .row_scan                (row_scan_counter_out),
      .mode                    (mode),
      .reorganized_address_out (reorganized_address_out),
      .decoder_address_in      (decoder_address_in)
   );

   // Address mapping: follows the mode bits in the same cycle
   a_byte_pass: assert property // RULE1
      (mode == CRTCFB_BYTE |-> reorganized_address_out == count_addr)
      else $error("byte mode not passthrough");
   a_word_nowrap: assert property // RULE2
      (mode == CRTCFB_WORDN |-> reorganized_address_out[0] == count_addr[15]
      && reorganized_address_out[15:1] == count_addr[14:0])
      else $error("word no-wrap mapping wrong");
   a_word_wrap: assert property // RULE3 RULE16
      (mode == CRTCFB_WORDW |-> reorganized_address_out[0] == count_addr[13]
      && reorganized_address_out[15:1] == count_addr[14:0])
      else $error("word wrap mapping wrong");
   a_dword_map: assert property // RULE4
      (underline_location_reg[UL_DWORD] |->
      reorganized_address_out[0] == count_addr[12]
      && reorganized_address_out[1] == count_addr[13]
      && reorganized_address_out[15:2] == count_addr[13:0])
      else $error("doubleword mapping wrong");
   a_row_subst: assert property // RULE5
      (decoder_address_in[13] == (crt_mode_control[MC_COMPAT] ?
      reorganized_address_out[13] : row_scan_counter_out[0])
      && decoder_address_in[14] == (crt_mode_control[MC_ROW_SEL] ?
      reorganized_address_out[14] : row_scan_counter_out[1])
      && decoder_address_in[15] == reorganized_address_out[15]
      && decoder_address_in[12:0] == reorganized_address_out[12:0])
      else $error("row scan substitution wrong");

   // Line compare, split and counter restart
   a_lcmp_value: assert property // RULE6
      (line_compare[9] == max_scan_line_reg[MS_LCMP_B9]
      && line_compare[8] == overflow_reg[OV_LCMP_B8]
      && line_compare[7:0] == line_compare_low)
      else $error("line compare assembly wrong");
   a_cmp_restart: assert property // RULE7
      (cmp_hit |=> count_addr == 16'h0000 && split_active)
      else $error("no restart at compare line");
   a_frame_start: assert property // RULE8
      (frame_start && !cmp_hit |=> count_addr == $past(start_address)
      && !split_active)
      else $error("frame not started at start address");
   a_line_reload: assert property // RULE8
      (line_start && !frame_start && !cmp_hit |=>
      count_addr == $past(line_base))
      else $error("line not reloaded from line base");

   // Register port
   a_index_load: assert property // RULE15
      (index_wr |=> index_value == $past(host_wdata))
      else $error("index not loaded");
   a_lcmp_write: assert property // RULE15 RULE6
      (data_wr && index_value == IDX_LINE_CMP |=>
      line_compare[7:0] == $past(host_wdata))
      else $error("line compare write lost");
   a_latch_read: assert property // RULE9
      (data_rd && index_value == IDX_LATCH_DATA |=>
      host_rdata == $past(latch_pick))
      else $error("latch data read wrong");

   // Vertical total
   a_vt_std: assert property // RULE10 RULE12
      (!ext_mode |-> vertical_total[11:10] == 2'b00
      && vertical_total[9] == overflow_reg[OV_VT_B9]
      && vertical_total[8] == overflow_reg[OV_VT_B8]
      && vertical_total[7:0] == vertical_total_low)
      else $error("standard vertical total wrong");
   a_vt_ext: assert property // RULE11
      (ext_mode |-> vertical_total[11:8] == vertical_total_high
      && vertical_total[7:0] == vertical_total_low)
      else $error("extended vertical total wrong");
   a_vt_readback: assert property // RULE11
      (data_rd && index_value == IDX_VTOTAL_HIGH |=>
      host_rdata == {4'h0, $past(vertical_total_high)})
      else $error("vertical total extension readback wrong");

   // Main scenarios reached
   c_split: cover property (cmp_hit);
   c_dword: cover property (mode == CRTCFB_DWORD);
   c_word_wrap: cover property (mode == CRTCFB_WORDW);
   c_row_subst: cover property (!crt_mode_control[MC_ROW_SEL]
      && !crt_mode_control[MC_COMPAT]);
   c_ext_vt: cover property (ext_mode && vertical_total[11:10] != 2'b00);
endmodule // crtcfb_top
`default_nettype wire

// File: tb/crtcfb_timing_model.sv
/*
 Model of the CRT timing that feeds the address mapper: line, frame and
 character strobes, scan line number and row scan counter.
 Assumes one mclk domain; strobes change only just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module crtcfb_timing_model
#(
   parameter int LINES  = 12,
   parameter int ACTIVE = 8
)
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   output logic            frame_start,
   output logic            line_start,
   output logic            char_advance,
   output logic            active_line,
   output logic [9:0]      scan_line,
   output logic [1:0]      row_scan,
   output logic            row_last
);
   logic [3:0] pos;

   // Sixteen mclk per line keeps a frame short for the bench
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         pos       <= 4'h0;
         scan_line <= 10'h000;
      end
      else
      begin
         pos <= pos + 4'h1;
         if (pos == 4'hF)
            scan_line <= (scan_line == 10'(LINES - 1)) ? 10'h000
                                                       : scan_line + 10'h001;
      end
   end

   // Strobes are decoded from the registered position, so no glitches
   assign line_start   = nrst && (pos == 4'h0);
   assign frame_start  = line_start && (scan_line == 10'h000);
   assign char_advance = nrst && (pos != 4'h0);
   assign active_line  = scan_line < 10'(ACTIVE);
   assign row_scan     = scan_line[1:0];
   assign row_last     = &scan_line[1:0];
endmodule // crtcfb_timing_model
`default_nettype wire

// File: tb/tb_top.sv
/*
 Self-checking bench for the frame buffer address mapper.
 Assumes the timing model drives the CRT strobes; host port by tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import crtcfb_pkg::*;
   logic        mclk, nrst, index_wr, data_wr, data_rd, ext_mode;
   logic [7:0]  host_wdata, host_rdata, index_value, mc, ul;
   logic [1:0]  read_map_select, rs;
   logic [31:0] read_latches;
   logic        fs, ls, ca, al, rl, split_active;
   logic [9:0]  sl, line_compare;
   logic [15:0] count_addr, reorg, dec;
   logic [11:0] vertical_total;
   int          fails, comparisons;
   logic [15:0] modes [7] = '{16'h00E3, 16'h00A3, 16'h0083, 16'h40E3,
                              16'h40A0, 16'h00E2, 16'h00E1};

   always #10 mclk = ~mclk;

   crtcfb_top DUT (.mclk(mclk), .nrst(nrst), .index_wr(index_wr),
      .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .index_value(index_value),
      .ext_mode(ext_mode), .read_map_select(read_map_select),
      .read_latches(read_latches), .frame_start(fs), .line_start(ls),
      .char_advance(ca), .active_line(al), .scan_line(sl),
      .row_scan_counter_out(rs), .row_last(rl), .count_addr(count_addr),
      .reorganized_address_out(reorg), .decoder_address_in(dec),
      .line_compare(line_compare), .vertical_total(vertical_total),
      .split_active(split_active));

   crtcfb_timing_model timing (.mclk(mclk), .nrst(nrst),
      .frame_start(fs), .line_start(ls), .char_advance(ca),
      .active_line(al), .scan_line(sl), .row_scan(rs), .row_last(rl));

   task automatic tally_and_finish();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Index then data access, one strobe per edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      @(posedge mclk);
      index_wr   <= 1'b1;
      host_wdata <= idx;
      @(posedge mclk);
      index_wr   <= 1'b0;
      data_wr    <= 1'b1;
      host_wdata <= v;
      @(posedge mclk);
      data_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge mclk);
      index_wr   <= 1'b1;
      host_wdata <= idx;
      @(posedge mclk);
      index_wr   <= 1'b0;
      data_rd    <= 1'b1;
      @(posedge mclk);
      data_rd    <= 1'b0;
      @(negedge mclk);
      chk("host_rdata", {8'h00, exp}, {8'h00, host_rdata});
   endtask

   // Bounded wait for the start of a given scan line
   task automatic wait_line(input logic [9:0] ln);
      for (int n = 0; n < 1000; n++)
      begin
         @(negedge mclk);
         if (ls === 1'b1 && sl === ln)
            return;
      end
      fails++;
      $display("BAD line wait expected %h seen none", ln);
      tally_and_finish();
   endtask

   // Expected mapping worked out from the mode table
   function automatic logic [15:0] remap(input logic [15:0] c,
                                          input logic [1:0] r,
                                          input logic sub);
      logic [15:0] m;
      if (ul[6])
         m = {c[13:0], c[13], c[12]};
      else if (mc[6])
         m = c;
      else if (mc[5])
         m = {c[14:0], c[15]};
      else
         m = {c[14:0], c[13]};
      if (sub && !mc[0])
         m[13] = r[0];
      if (sub && !mc[1])
         m[14] = r[1];
      return m;
   endfunction

   initial
   begin
      {mclk, nrst, index_wr, data_wr, data_rd, ext_mode} = 6'h00;
      {host_wdata, read_map_select, fails, comparisons} = '0;
      read_latches = 32'hC4B3A291;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      @(negedge mclk);
      chk("line_compare", 16'h03FF, 16'(line_compare));
      chk("vertical_total", 16'h0000, 16'(vertical_total));
      rd(IDX_LINE_CMP, 8'hFF);
      chk("index_value", 16'(IDX_LINE_CMP), 16'(index_value));
      // Unknown index right after a nonzero read, so stale data shows
      rd(8'h3F, 8'h00);
      rd(IDX_VTOTAL_HIGH, 8'h00);
      // Bits 15 and 13 differ so the two word modes can be told apart
      wr(IDX_START_HIGH, 8'h96);
      wr(IDX_START_LOW, 8'hD9);
      for (int m = 0; m < 7; m++)
      begin
         ul = modes[m][15:8];
         mc = modes[m][7:0];
         wr(IDX_UNDERLINE, ul);
         wr(IDX_MODE_CTRL, mc);
         for (int k = 0; k < 200; k++)
         begin
            @(negedge mclk);
            chk("reorganized", remap(count_addr, rs, 1'b0), reorg);
            chk("decoder", remap(count_addr, rs, 1'b1), dec);
         end
      end
      wr(IDX_START_HIGH, 8'h12);
      wr(IDX_START_LOW, 8'h34);
      wr(IDX_OVERFLOW, 8'h00);
      wr(IDX_MAX_SCAN, 8'h00);
      wr(IDX_LINE_CMP, 8'h05);
      @(negedge mclk);
      chk("line_compare", 16'h0005, 16'(line_compare));
      wait_line(10'h000);
      @(negedge mclk);
      chk("count_addr", 16'h1234, count_addr);
      chk("split_active", 16'h0000, 16'(split_active));
      wait_line(10'h005);
      @(negedge mclk);
      chk("count_addr", 16'h0000, count_addr);
      chk("split_active", 16'h0001, 16'(split_active));
      // The next active line starts from the first byte again
      wait_line(10'h006);
      @(negedge mclk);
      chk("count_addr", 16'h0000, count_addr);
      wr(IDX_OVERFLOW, 8'h10);
      @(negedge mclk);
      chk("line_compare", 16'h0105, 16'(line_compare));
      wr(IDX_OVERFLOW, 8'h00);
      wr(IDX_MAX_SCAN, 8'h40);
      @(negedge mclk);
      chk("line_compare", 16'h0205, 16'(line_compare));
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk);
         read_map_select <= 2'(k);
         rd(IDX_LATCH_DATA, read_latches[8*k+:8]);
      end
      // A write must not disturb the latch view
      wr(IDX_LATCH_DATA, 8'h5A);
      rd(IDX_LATCH_DATA, 8'hC4);
      // 924 scan lines programmed as 922
      wr(IDX_VTOTAL_LOW, 8'h9A);
      wr(IDX_OVERFLOW, 8'h21);
      wr(IDX_VTOTAL_HIGH, 8'h05);
      @(negedge mclk);
      chk("vertical_total", 16'h039A, 16'(vertical_total));
      @(posedge mclk);
      ext_mode <= 1'b1;
      @(negedge mclk);
      chk("vertical_total", 16'h059A, 16'(vertical_total));
      rd(IDX_VTOTAL_HIGH, 8'h05);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
